/* shared/input_mapper_map.vh */
// Register map, selection codes and fixed assignments of the input mapper.
// Behaviour
// - Each input has selector; configurable inputs route per selection
// - Local mode: allowed functions follow startup mode
// - Enable and power-removal inputs are fixed
// - Fieldbus mode offers only the listed functions
// - Code 1 leaves input unassigned
// - Code 2 resets pending error
// - Code 5 starts positioning, fieldbus only
// - Code 6 enables positive move, local only
// - Code 7 enables negative move, local only
// - Code 8 limits speed, local only
// - Code 9 jogs clockwise, jog mode only
// - Code 10 jogs counterclockwise, jog only
// - Code 13 is motion-sequence start request
// - Code 14 selects sequence restart from zero
// - Code 20 is homing reference switch
// - Code 21 is positive travel limit
// - Code 22 is negative travel limit
// - Positioning starts on input rising edge
// - Positive switch falling edge locks positive references
`ifndef INPUT_MAPPER_MAP_VH
`define INPUT_MAPPER_MAP_VH
`define SEL_BASE_ADDR 16'h0702
`define SEL_RESET 16'h0000
`define CODE_FREE 16'h0001
`define CODE_FAULT_RESET 16'h0002
`define CODE_HALT 16'h0004
`define CODE_START_POS 16'h0005
`define CODE_POS_ENABLE 16'h0006
`define CODE_NEG_ENABLE 16'h0007
`define CODE_SPEED_LIMIT 16'h0008
`define CODE_JOG_POS 16'h0009
`define CODE_JOG_NEG 16'h000A
`define CODE_JOG_FAST 16'h000B
`define CODE_SEQ_START 16'h000D
`define CODE_SEQ_SELECT 16'h000E
`define CODE_REF_SWITCH 16'h0014
`define CODE_POS_LIMIT 16'h0015
`define CODE_NEG_LIMIT 16'h0016
`define CODE_ENABLE2 16'h0017
`define MODE_JOG 2'h0
`define MODE_GEAR 2'h1
`define MODE_SPEED 2'h2
`define MODE_CURRENT 2'h3
`endif

/* core/digital_input_function_mapper.v */
// Routes seven digital inputs to drive functions under selection registers.
`include "input_mapper_map.vh"
module digital_input_function_mapper (
   input wire i_ref_clk,
   input wire i_reset,
   input wire [6:0] i_digital_inputs,
   input wire i_fieldbus_mode,
   input wire [1:0] i_startup_mode,
   input wire i_wr_en,
   input wire [15:0] i_addr,
   input wire [15:0] i_wr_data,
   output reg [15:0] o_rd_data,
   output reg o_wr_reject,
   output reg o_fault_reset,
   output reg o_enable,
   output reg o_halt,
   output reg o_power_removal_a,
   output reg o_power_removal_b,
   output reg o_start_positioning,
   output reg o_pos_move_enable,
   output reg o_neg_move_enable,
   output reg o_pos_ref_locked,
   output reg o_speed_limit,
   output reg o_jog_pos,
   output reg o_jog_neg,
   output reg o_jog_fast,
   output reg o_enable2,
   output reg o_seq_start,
   output reg o_seq_select,
   output reg o_reference_switch,
   output reg o_positive_travel_limit,
   output reg o_negative_travel_limit
);
   // Selector registers for inputs one to seven at consecutive addresses.
   reg [15:0] sel_r [0:6];
   reg [6:0] sync1_r;
   reg [6:0] sync2_r;
   reg [6:0] prev_r;
   reg pos_switch_prev_r;
   reg pos_lock_r;
   wire [15:0] idx = i_addr - `SEL_BASE_ADDR;
   wire addr_hit = (i_addr >= `SEL_BASE_ADDR) && (idx < 16'h0007);
   wire [2:0] widx = idx[2:0];

   // Legality of a code on a given input under the present modes.
   function code_ok;
      input [2:0] n;
      input [15:0] c;
      input fb;
      input [1:0] sm;
      reg cfg;
      begin
         // Inputs one, two, four and seven carry configurable functions.
         cfg = (n == 3'd0) || (n == 3'd1) || (n == 3'd3) || (n == 3'd6);
         code_ok = 1'b0;
         if (cfg) begin
            if (fb) begin
               case (c)
                  `CODE_FREE: code_ok = 1'b1;
                  `CODE_START_POS: code_ok = 1'b1;
                  `CODE_HALT: code_ok = (n == 3'd3);
                  `CODE_REF_SWITCH: code_ok = (n == 3'd0);
                  `CODE_NEG_LIMIT: code_ok = (n == 3'd1);
                  default: code_ok = 1'b0;
               endcase
            end else begin
               case (c)
                  `CODE_FREE: code_ok = 1'b1;
                  `CODE_FAULT_RESET: code_ok = (n == 3'd1);
                  `CODE_HALT: code_ok = (n == 3'd3);
                  `CODE_POS_ENABLE, `CODE_NEG_ENABLE:
                     code_ok = (sm == `MODE_GEAR) || (sm == `MODE_SPEED);
                  `CODE_SPEED_LIMIT:
                     code_ok = (sm != `MODE_JOG);
                  `CODE_JOG_POS, `CODE_JOG_NEG,
                  `CODE_JOG_FAST:
                     code_ok = (sm == `MODE_JOG);
                  `CODE_ENABLE2: code_ok = (n == 3'd6);
                  `CODE_SEQ_START, `CODE_SEQ_SELECT: code_ok = 1'b1;
                  default: code_ok = 1'b0;
               endcase
            end
         end
      end
   endfunction

   integer k;
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         for (k = 0; k < 7; k = k + 1) begin
            sel_r[k] <= `SEL_RESET;
         end
         o_wr_reject <= 1'b0;
      end else begin
         o_wr_reject <= 1'b0;
         if (i_wr_en && addr_hit) begin
            if (code_ok(widx, i_wr_data, i_fieldbus_mode, i_startup_mode))
               sel_r[widx] <= i_wr_data;
            else
               o_wr_reject <= 1'b1;
         end else if (i_wr_en) begin
            o_wr_reject <= 1'b1;
         end
      end
   end

   always @(*) begin
      o_rd_data = 16'h0000;
      if (addr_hit) begin
         o_rd_data = sel_r[widx];
      end
   end

   // Pin inputs pass two flops before any use.
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
         prev_r <= 7'h00;
      end else begin
         sync1_r <= i_digital_inputs;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // A code stored under one mode may be illegal after a mode change, so
   // every route is re-gated by the current legality.
   reg [6:0] act;
   reg f_fr, f_ha, f_sp, f_pe, f_ne, f_sl, f_jp, f_jn, f_jf;
   reg f_e2, f_ss, f_sx, f_rf, f_pl, f_nl;
   integer j;
   always @(*) begin
      f_fr = 1'b0; f_ha = 1'b0; f_sp = 1'b0; f_pe = 1'b0; f_ne = 1'b0;
      f_sl = 1'b0; f_jp = 1'b0; f_jn = 1'b0; f_jf = 1'b0; f_e2 = 1'b0;
      f_ss = 1'b0; f_sx = 1'b0; f_rf = 1'b0; f_pl = 1'b0; f_nl = 1'b0;
      act = 7'h00;
      for (j = 0; j < 7; j = j + 1) begin
         if (code_ok(j[2:0], sel_r[j], i_fieldbus_mode, i_startup_mode)) begin
            act[j] = 1'b1;
            case (sel_r[j])
               `CODE_FAULT_RESET: f_fr = f_fr | sync2_r[j];
               `CODE_HALT: f_ha = f_ha | sync2_r[j];
               `CODE_START_POS:
                  f_sp = f_sp | (sync2_r[j] & ~prev_r[j]);
               `CODE_POS_ENABLE: f_pe = f_pe | sync2_r[j];
               `CODE_NEG_ENABLE: f_ne = f_ne | sync2_r[j];
               `CODE_SPEED_LIMIT: f_sl = f_sl | sync2_r[j];
               `CODE_JOG_POS: f_jp = f_jp | sync2_r[j];
               `CODE_JOG_NEG: f_jn = f_jn | sync2_r[j];
               `CODE_JOG_FAST: f_jf = f_jf | sync2_r[j];
               `CODE_ENABLE2: f_e2 = f_e2 | sync2_r[j];
               `CODE_SEQ_START: f_ss = f_ss | sync2_r[j];
               `CODE_SEQ_SELECT: f_sx = f_sx | sync2_r[j];
               `CODE_REF_SWITCH: f_rf = f_rf | sync2_r[j];
               `CODE_POS_LIMIT: f_pl = f_pl | sync2_r[j];
               `CODE_NEG_LIMIT: f_nl = f_nl | sync2_r[j];
               default: act[j] = 1'b0;
            endcase
         end
      end
   end

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         pos_switch_prev_r <= 1'b0;
         pos_lock_r <= 1'b0;
         o_fault_reset <= 1'b0;
         o_enable <= 1'b0;
         o_halt <= 1'b0;
         o_power_removal_a <= 1'b0;
         o_power_removal_b <= 1'b0;
         o_start_positioning <= 1'b0;
         o_pos_move_enable <= 1'b0;
         o_neg_move_enable <= 1'b0;
         o_pos_ref_locked <= 1'b0;
         o_speed_limit <= 1'b0;
         o_jog_pos <= 1'b0;
         o_jog_neg <= 1'b0;
         o_jog_fast <= 1'b0;
         o_enable2 <= 1'b0;
         o_seq_start <= 1'b0;
         o_seq_select <= 1'b0;
         o_reference_switch <= 1'b0;
         o_positive_travel_limit <= 1'b0;
         o_negative_travel_limit <= 1'b0;
      end else begin
         // Input three is enable locally, the positive limit on fieldbus.
         o_enable <= ~i_fieldbus_mode & sync2_r[2];
         o_positive_travel_limit <= f_pl |
            (i_fieldbus_mode & sync2_r[2]);
         o_power_removal_a <= sync2_r[4];
         o_power_removal_b <= sync2_r[5];
         o_fault_reset <= f_fr;
         o_halt <= f_ha;
         o_start_positioning <= f_sp & i_fieldbus_mode;
         o_pos_move_enable <= f_pe;
         o_neg_move_enable <= f_ne;
         // A falling switch edge sets the lock and a rising edge clears it, so only
         // negative references run until the switch is active again.
         pos_switch_prev_r <= f_pe;
         if (f_pe != pos_switch_prev_r)
            pos_lock_r <= ~f_pe;
         o_pos_ref_locked <= pos_lock_r;
         o_speed_limit <= f_sl;
         o_jog_pos <= f_jp;
         o_jog_neg <= f_jn;
         o_jog_fast <= f_jf;
         o_enable2 <= f_e2;
         o_seq_start <= f_ss;
         o_seq_select <= f_sx;
         o_reference_switch <= f_rf;
         o_negative_travel_limit <= f_nl;
      end
   end
endmodule

/* sim/mapper_checker.sv */
// Checker of write refusals and mode gating at the mapper's ports.
module mapper_checker (
   input wire i_ref_clk,
   input wire i_reset,
   input wire i_fieldbus_mode,
   input wire [1:0] i_startup_mode,
   input wire i_wr_en,
   input wire [15:0] i_addr,
   input wire [15:0] i_wr_data,
   input wire [15:0] o_rd_data,
   input wire o_wr_reject,
   input wire o_start_positioning,
   input wire o_pos_move_enable,
   input wire o_speed_limit,
   input wire o_jog_pos,
   input wire o_jog_neg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);
   // Modes are held three cycles so the registered outputs can settle.
   rej_cause_a: assert property (o_wr_reject |-> $past(i_wr_en))
      else $error("refusal without a write");
   fixed_sel_a: assert property (
      i_wr_en && (i_addr == 16'h0704 ||
      i_addr == 16'h0706 || i_addr == 16'h0707) |=> o_wr_reject)
      else $error("fixed input selector accepted");
   bad_addr_a: assert property (
      i_wr_en && (i_addr < 16'h0702 ||
      i_addr > 16'h0708) |=> o_wr_reject) else $error("bad address taken");
   wr_take_a: assert property (i_wr_en ##1 (!o_wr_reject &&
      $stable(i_addr)) |-> o_rd_data == $past(i_wr_data))
      else $error("accepted code not stored");
   pos_pulse_a: assert property (o_start_positioning
      |=> !o_start_positioning) else $error("start pulse too long");
   fb_nojog_a: assert property (i_fieldbus_mode [*3] |->
      !o_jog_pos && !o_jog_neg && !o_speed_limit)
      else $error("local function in fieldbus mode");
   lc_nostart_a: assert property ((!i_fieldbus_mode) [*3]
      |-> !o_start_positioning) else $error("start in local mode");
   jog_only_a: assert property (
      (i_startup_mode != 2'h0) [*3]
      |-> !o_jog_pos && !o_jog_neg) else $error("jog outside jog mode");
   cur_move_a: assert property ((!i_fieldbus_mode &&
      i_startup_mode == 2'h3) [*3] |-> !o_pos_move_enable)
      else $error("move enable in current mode");
   cover property (o_wr_reject);
   cover property (o_start_positioning);
   cover property (o_jog_pos ##1 o_jog_pos);
endmodule
bind digital_input_function_mapper mapper_checker chk_i (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset),
   .i_fieldbus_mode(i_fieldbus_mode), .i_startup_mode(i_startup_mode),
   .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
   .o_rd_data(o_rd_data), .o_wr_reject(o_wr_reject),
   .o_start_positioning(o_start_positioning),
   .o_pos_move_enable(o_pos_move_enable), .o_speed_limit(o_speed_limit),
   .o_jog_pos(o_jog_pos), .o_jog_neg(o_jog_neg));

/* sim/switch_bank_model.sv */
// Switch bank model that drives the mapper's digital input pins.
module switch_bank_model (
   input wire i_ref_clk,
   input wire [6:0] i_press,
   output logic [6:0] o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Contacts follow the command a cycle late, so pins change only on a rising clock edge.
   initial o_pins = 7'h00;
   always @(posedge i_ref_clk) o_pins <= i_press;
endmodule

/* sim/digital_input_function_mapper_tb.sv */
// Self-checking bench for the digital input function mapper.
module digital_input_function_mapper_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 1'h0, i_reset = 1'h1, i_fieldbus_mode = 1'h1;
   logic i_wr_en = 1'h0, wr_d = 1'h0;
   logic [1:0] i_startup_mode = 2'h0;
   logic [15:0] i_addr = 16'h0000, i_wr_data = 16'h0000;
   logic [6:0] press = 7'h00;
   wire [6:0] pins;
   wire [15:0] o_rd_data;
   wire o_wr_reject;
   wire [18:0] outs;
   logic q[$];
   int err_count = 0, compares = 0, seed = 65756;
   switch_bank_model sw (.i_ref_clk(i_ref_clk), .i_press(press),
      .o_pins(pins));
   digital_input_function_mapper dut (.i_ref_clk(i_ref_clk),
      .i_reset(i_reset), .i_digital_inputs(pins),
      .i_fieldbus_mode(i_fieldbus_mode), .i_startup_mode(i_startup_mode),
      .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
      .o_rd_data(o_rd_data), .o_wr_reject(o_wr_reject),
      .o_fault_reset(outs[0]), .o_enable(outs[1]), .o_halt(outs[2]),
      .o_power_removal_a(outs[3]), .o_power_removal_b(outs[4]),
      .o_start_positioning(outs[5]), .o_pos_move_enable(outs[6]),
      .o_neg_move_enable(outs[7]), .o_pos_ref_locked(outs[8]),
      .o_speed_limit(outs[9]), .o_jog_pos(outs[10]), .o_jog_neg(outs[11]),
      .o_jog_fast(outs[12]), .o_enable2(outs[13]), .o_seq_start(outs[14]),
      .o_seq_select(outs[15]), .o_reference_switch(outs[16]),
      .o_positive_travel_limit(outs[17]),
      .o_negative_travel_limit(outs[18]));
   initial forever #4 i_ref_clk = ~i_ref_clk;
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // The refusal flag is noted when the write is driven and checked later.
   task automatic wr(input fb, input [1:0] sm, input [2:0] n,
      input [15:0] c, input rej);
      @(posedge i_ref_clk);
      i_fieldbus_mode <= fb;
      i_startup_mode <= sm;
      i_addr <= 16'h0702 + n;
      i_wr_data <= c;
      i_wr_en <= 1'h1;
      q.push_back(rej);
      @(posedge i_ref_clk);
      i_wr_en <= 1'h0;
   endtask
   task automatic rd(input [2:0] n, input [15:0] e);
      @(posedge i_ref_clk);
      i_addr <= 16'h0702 + n;
      @(negedge i_ref_clk);
      chk(o_rd_data, e);
   endtask
   task automatic wait_out(input int b, input logic v);
      int k;
      k = 0;
      while (outs[b] !== v && k < 20) begin
         @(negedge i_ref_clk);
         k++;
      end
      chk(outs[b], v);
      if (k == 20) finish_test();
   endtask
   always @(posedge i_ref_clk) begin
      if (wr_d) chk(o_wr_reject, q.pop_front());
      wr_d <= i_wr_en;
   end
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_reset <= 1'h0;
      for (int n = 0; n < 7; n++) rd(3'(n), 16'h0000);
      wr(1'h1, 2'h0, 3'h0, 16'h0014, 1'h0);
      wr(1'h1, 2'h0, 3'h1, 16'h0016, 1'h0);
      wr(1'h1, 2'h0, 3'h3, 16'h0004, 1'h0);
      wr(1'h1, 2'h0, 3'h6, 16'h0005, 1'h0);
      wr(1'h1, 2'h0, 3'h0, 16'h0009, 1'h1);
      wr(1'h1, 2'h0, 3'h1, 16'h0006, 1'h1);
      wr(1'h1, 2'h0, 3'h2, 16'h0001, 1'h1);
      wr(1'h1, 2'h0, 3'h4, 16'h0001, 1'h1);
      wr(1'h1, 2'h0, 3'h5, 16'h0001, 1'h1);
      wr(1'h1, 2'h0, 3'h3, 16'h0003, 1'h1);
      wr(1'h1, 2'h0, 3'h7, 16'($random(seed)), 1'h1);
      rd(3'h0, 16'h0014);
      @(posedge i_ref_clk) press <= 7'h49;
      wait_out(5, 1'h1);
      wait_out(16, 1'h1);
      wait_out(2, 1'h1);
      @(posedge i_ref_clk) press <= 7'h36;
      wait_out(18, 1'h1);
      wait_out(17, 1'h1);
      wait_out(3, 1'h1);
      wait_out(4, 1'h1);
      wr(1'h0, 2'h0, 3'h0, 16'h0009, 1'h0);
      wr(1'h0, 2'h0, 3'h1, 16'h000A, 1'h0);
      wr(1'h0, 2'h0, 3'h3, 16'h0006, 1'h1);
      wr(1'h0, 2'h0, 3'h6, 16'h0005, 1'h1);
      @(posedge i_ref_clk) press <= 7'h0F;
      wait_out(10, 1'h1);
      wait_out(11, 1'h1);
      wait_out(1, 1'h1);
      wr(1'h0, 2'h1, 3'h0, 16'h0006, 1'h0);
      wait_out(11, 1'h0);
      wait_out(6, 1'h1);
      wr(1'h0, 2'h1, 3'h1, 16'h0007, 1'h0);
      wait_out(7, 1'h1);
      wr(1'h0, 2'h1, 3'h3, 16'h0008, 1'h0);
      wait_out(9, 1'h1);
      @(posedge i_ref_clk) press <= 7'h0E;
      wait_out(8, 1'h1);
      wr(1'h0, 2'h3, 3'h0, 16'h0006, 1'h1);
      wr(1'h0, 2'h3, 3'h0, 16'h0008, 1'h0);
      wr(1'h0, 2'h0, 3'h1, 16'h0002, 1'h0);
      wait_out(0, 1'h1);
      wr(1'h0, 2'h0, 3'h1, 16'h0001, 1'h0);
      wait_out(0, 1'h0);
      wr(1'h0, 2'h0, 3'h3, 16'h000E, 1'h0);
      wait_out(15, 1'h1);
      wr(1'h0, 2'h0, 3'h1, 16'h000B, 1'h0);
      wait_out(12, 1'h1);
      wr(1'h0, 2'h0, 3'h1, 16'h000D, 1'h0);
      wait_out(14, 1'h1);
      wait_out(12, 1'h0);
      @(posedge i_ref_clk) press <= 7'h4E;
      wr(1'h0, 2'h0, 3'h6, 16'h0017, 1'h0);
      wait_out(13, 1'h1);
      repeat (2) @(posedge i_ref_clk);
      finish_test();
   end
endmodule
